// *** shared/rtsa_cfg.svh ***
`ifndef RTSA_CFG_SVH
`define RTSA_CFG_SVH
// time base and subsecond tick
`define RTSA_TB_HZ 32768
`define RTSA_SUB_TICKS 4096
`define RTSA_SUB_W 12
// time base cycles per subsecond tick (32768 / 4096)
`define RTSA_TB_PER_TICK 8
// alarm window: 12 days in seconds
`define RTSA_TOD_MAX_AHEAD 32'd1036800
`define RTSA_TOD_MIN_AHEAD 32'd1
// calibration trim in ppm
`define RTSA_TRIM_MAX 127
// trim accumulator: one million time base cycles per ppm unit
`define RTSA_PPM_BASE 20'd1000000
// square wave select codes
`define RTSA_SQW_1HZ 2'd0
`define RTSA_SQW_512HZ 2'd1
`define RTSA_SQW_4KHZ 2'd2
`define RTSA_SQW_TB 2'd3
`endif

// *** shared/rtsa_pkg.sv ***
package rtsa_pkg;
   typedef enum logic [1:0] {rtsa_alm_off, rtsa_alm_once, rtsa_alm_repeat} rtsa_alm_mode_t;
   typedef logic [1:0] rtsa_sqw_sel_t;
endpackage : rtsa_pkg

// *** rtl/rtsa_sync.sv ***
`timescale 1ns/1ns
`include "rtsa_cfg.svh"
// three flop input stage; change accepted when stages two and three agree
module rtsa_sync (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // pin in, clean level out
   input wire logic din,
   output logic dout
);
   logic s1_r, s2_r, s3_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) dout <= s3_r;
      end
   end
endmodule : rtsa_sync

// *** rtl/rtsa_top.sv ***
`timescale 1ns/1ns
`include "rtsa_cfg.svh"
module rtsa_top
   import rtsa_pkg::*;
#(
   parameter int TB_PER_TICK = `RTSA_TB_PER_TICK,
   parameter int PPM_BASE = `RTSA_PPM_BASE
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // time base pins
   input wire logic xtal_clk_in,
   input wire logic ext_clk_in,
   input wire logic ext_sel,
   // control
   input wire logic run_en,
   input wire logic sec_load,
   input wire logic [31:0] sec_load_val,
   input wire logic signed [7:0] trim_ppm,
   // time-of-day alarm
   input wire logic tod_arm,
   input wire logic tod_repeat,
   input wire logic [31:0] tod_target,
   input wire logic tod_ack,
   // subsecond alarm
   input wire logic sub_arm,
   input wire logic sub_repeat,
   input wire logic [31:0] sub_interval,
   input wire logic sub_ack,
   // interrupt and wake
   input wire logic irq_en,
   input wire logic wake_en,
   // square wave
   input wire logic sqw_en,
   input wire rtsa_sqw_sel_t sqw_sel,
   // status out
   output logic [31:0] seconds,
   output logic [11:0] subsec,
   output logic tod_flag,
   output logic sub_flag,
   output logic tod_armed,
   output logic sub_armed,
   output logic tod_reject,
   output logic irq,
   output logic wake_req,
   output logic square_wave_output
);
   // 255 would let a doubled edge wrap the 8-bit divider past its limit
   if (TB_PER_TICK < 1 || TB_PER_TICK > 254) begin : g_bad_tick
      $error("TB_PER_TICK out of range");
   end
   if (PPM_BASE < 1000 || PPM_BASE > 1048575) begin : g_bad_ppm
      $error("PPM_BASE out of range");
   end

   logic xtal_s, ext_s, tb_lvl, tb_prev_r, tb_rise;
   logic [7:0] div_r;
   logic [19:0] ppm_acc_r;
   logic tick_r, tb_edge_ok, skip_r, extra_r;
   logic [31:0] sub_cnt_r;
   logic [31:0] tod_tgt_r, tod_dist_r;
   logic tod_rep_r, sub_rep_r;
   logic [31:0] sub_int_r;
   logic [31:0] ahead;
   logic sec_wrap;
   logic [8:0] trim_mag;

   rtsa_sync u_sx (.core_clk(core_clk), .rst(rst), .din(xtal_clk_in), .dout(xtal_s));
   rtsa_sync u_se (.core_clk(core_clk), .rst(rst), .din(ext_clk_in), .dout(ext_s));

   assign tb_lvl = ext_sel ? ext_s : xtal_s;
   assign tb_rise = tb_lvl & ~tb_prev_r;
   // -128 lies outside the trim range and is held to the limit
   assign trim_mag = (trim_ppm == 8'sh80) ? 9'(`RTSA_TRIM_MAX) :
      trim_ppm[7] ? 9'(-$signed({trim_ppm[7], trim_ppm})) : {1'b0, trim_ppm};

   always_ff @(posedge core_clk) begin
      if (rst) tb_prev_r <= 1'b0;
      else tb_prev_r <= tb_lvl;
   end

   // ppm accumulator: every PPM_BASE time base edges, trim_mag edges dropped or added
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ppm_acc_r <= 20'h0;
         skip_r <= 1'b0;
         extra_r <= 1'b0;
      end else if (tb_rise && run_en) begin
         skip_r <= 1'b0;
         extra_r <= 1'b0;
         if ({12'h0, ppm_acc_r} + 32'(trim_mag) >= 32'(PPM_BASE)) begin
            ppm_acc_r <= 20'(32'(ppm_acc_r) + 32'(trim_mag) - 32'(PPM_BASE));
            if (trim_ppm[7]) skip_r <= 1'b1;
            else extra_r <= 1'b1;
         end else begin
            ppm_acc_r <= ppm_acc_r + 20'(trim_mag);
         end
      end
   end

   // negative trim swallows one edge; positive trim counts one edge twice
   assign tb_edge_ok = tb_rise && run_en && !skip_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_r <= 8'h0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (tb_edge_ok) begin
            if (div_r + (extra_r ? 8'h2 : 8'h1) >= 8'(TB_PER_TICK)) begin
               div_r <= 8'h0;
               tick_r <= 1'b1;
            end else begin
               div_r <= div_r + (extra_r ? 8'h2 : 8'h1);
            end
         end
      end
   end

   assign sec_wrap = tick_r && (subsec == 12'hfff);

   // seconds and subsecond counters
   always_ff @(posedge core_clk) begin
      if (rst) begin
         seconds <= 32'h0;
         subsec <= 12'h0;
      end else if (sec_load) begin
         seconds <= sec_load_val;
         subsec <= 12'h0;
      end else if (tick_r) begin
         subsec <= subsec + 12'h1;
         if (sec_wrap) seconds <= seconds + 32'h1;
      end
   end

   // time-of-day alarm
   assign ahead = tod_target - seconds;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tod_armed <= 1'b0;
         tod_reject <= 1'b0;
         tod_tgt_r <= 32'h0;
         tod_dist_r <= 32'h0;
         tod_rep_r <= 1'b0;
      end else if (tod_arm) begin
         tod_rep_r <= tod_repeat;
         tod_tgt_r <= tod_target;
         tod_dist_r <= ahead;
         if (ahead >= `RTSA_TOD_MIN_AHEAD && ahead <= `RTSA_TOD_MAX_AHEAD) begin
            tod_armed <= 1'b1;
            tod_reject <= 1'b0;
         end else begin
            tod_armed <= 1'b0;
            tod_reject <= 1'b1;
         end
      end else if (tod_armed && sec_wrap && (seconds + 32'h1 == tod_tgt_r)) begin
         // repeat re-arms at the distance captured when the alarm was set
         if (tod_rep_r) tod_tgt_r <= tod_tgt_r + tod_dist_r;
         else tod_armed <= 1'b0;
      end
   end

   logic tod_hit, sub_hit;
   assign tod_hit = tod_armed && sec_wrap && (seconds + 32'h1 == tod_tgt_r);

   // subsecond alarm: down counter of 1/4096 s ticks
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sub_armed <= 1'b0;
         sub_cnt_r <= 32'h0;
         sub_int_r <= 32'h0;
         sub_rep_r <= 1'b0;
      end else if (sub_arm) begin
         sub_armed <= (sub_interval != 32'h0);
         sub_cnt_r <= sub_interval;
         sub_int_r <= sub_interval;
         sub_rep_r <= sub_repeat;
      end else if (sub_armed && tick_r) begin
         if (sub_cnt_r == 32'h1) begin
            if (sub_rep_r) sub_cnt_r <= sub_int_r;
            else sub_armed <= 1'b0;
         end else begin
            sub_cnt_r <= sub_cnt_r - 32'h1;
         end
      end
   end

   assign sub_hit = sub_armed && tick_r && (sub_cnt_r == 32'h1);

   // sticky flags: a hit in the ack cycle keeps the flag set
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tod_flag <= 1'b0;
         sub_flag <= 1'b0;
      end else begin
         tod_flag <= tod_hit | (tod_flag & ~tod_ack);
         sub_flag <= sub_hit | (sub_flag & ~sub_ack);
      end
   end

   // wake runs from flags and hits with no ack mask, registered on core_clk like irq
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         irq <= irq_en & ((tod_flag & ~tod_ack) | (sub_flag & ~sub_ack) | tod_hit | sub_hit);
         wake_req <= wake_en & (tod_flag | sub_flag | tod_hit | sub_hit);
      end
   end

   // square wave from the calibrated count chain, except the TB code and, with TB_PER_TICK below 2, the 4 kHz code, which give the raw time base
   always_ff @(posedge core_clk) begin
      if (rst) square_wave_output <= 1'b0;
      else if (!sqw_en) square_wave_output <= 1'b0;
      else begin
         case (sqw_sel)
            `RTSA_SQW_1HZ: square_wave_output <= subsec[11];
            `RTSA_SQW_512HZ: square_wave_output <= subsec[2];
            // a one-edge divider has no half phase, so the time base itself is the tick rate
            `RTSA_SQW_4KHZ: square_wave_output <= (TB_PER_TICK < 2) ? tb_lvl :
               (div_r < 8'(TB_PER_TICK / 2));
            `RTSA_SQW_TB: square_wave_output <= tb_lvl;
            default: square_wave_output <= 1'b0;
         endcase
      end
   end
endmodule : rtsa_top

// *** bench/rtsa_top_asserts.sv ***
`timescale 1ns/1ns
module rtsa_chk (
   // clock, reset and controls
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sec_load,
   input wire logic [31:0] sec_load_val,
   input wire logic tod_arm,
   input wire logic [31:0] tod_target,
   input wire logic tod_ack,
   input wire logic sub_ack,
   input wire logic irq_en,
   input wire logic wake_en,
   // status
   input wire logic [31:0] seconds,
   input wire logic [11:0] subsec,
   input wire logic tod_flag,
   input wire logic sub_flag,
   input wire logic tod_armed,
   input wire logic tod_reject,
   input wire logic irq,
   input wire logic wake_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence hit_s; tod_flag || sub_flag; endsequence
   // an acked flag drops the interrupt at once, a wake request lingers one cycle
   sequence live_s; (tod_flag && !tod_ack) || (sub_flag && !sub_ack); endsequence
   sequence far_s; tod_arm && (tod_target - seconds - 32'h1 > 32'd1036799); endsequence
   rst_clear_a: assert property (disable iff (1'b0) rst |=> !tod_flag && !irq && !tod_armed)
      else $error("state left after reset");
   irq_follow_a: assert property (live_s ##0 irq_en |=> irq)
      else $error("irq missed");
   wake_follow_a: assert property (hit_s ##0 wake_en |=> wake_req)
      else $error("wake missed");
   tod_refuse_a: assert property (far_s |=> tod_reject && !tod_armed)
      else $error("bad target armed");
   tod_accept_a: assert property (tod_arm && tod_target - seconds - 32'h1 < 32'd1036800
      |=> tod_armed && !tod_reject) else $error("good target refused");
   flag_hold_a: assert property (tod_flag && !tod_ack |=> tod_flag)
      else $error("flag dropped");
   sub_hold_a: assert property (sub_flag && !sub_ack |=> sub_flag)
      else $error("sub flag dropped");
   irq_gate_a: assert property (!irq_en |=> !irq)
      else $error("irq while disabled");
   sec_load_a: assert property (sec_load |=> seconds == $past(sec_load_val) && subsec == 12'h000)
      else $error("load lost");
   sec_step_a: assert property (!$past(rst) && !$past(sec_load) && seconds != $past(seconds)
      |-> seconds == $past(seconds) + 32'h1 && subsec == 12'h000) else $error("bad step");
endmodule : rtsa_chk
bind rtsa_top rtsa_chk rtsa_chk_i (
   .core_clk(core_clk), .rst(rst), .sec_load(sec_load), .sec_load_val(sec_load_val),
   .tod_arm(tod_arm), .tod_target(tod_target), .tod_ack(tod_ack), .sub_ack(sub_ack),
   .irq_en(irq_en), .wake_en(wake_en), .seconds(seconds), .subsec(subsec),
   .tod_flag(tod_flag), .sub_flag(sub_flag), .tod_armed(tod_armed),
   .tod_reject(tod_reject), .irq(irq), .wake_req(wake_req)
);

// *** bench/rtsa_top_tb.sv ***
`timescale 1ns/1ns
module rtsa_top_tb;
   import rtsa_pkg::*;
   logic core_clk, rst, xtal_clk_in, ext_clk_in, ext_sel, run_en, sec_load, tod_arm;
   logic tod_repeat, tod_ack, sub_arm, sub_repeat, sub_ack, irq_en, wake_en, sqw_en, sq;
   logic [31:0] sec_load_val, tod_target, sub_interval, seconds, rnd, exp_q[$];
   logic signed [7:0] trim_ppm;
   rtsa_sqw_sel_t sqw_sel;
   logic [11:0] subsec;
   logic tod_flag, sub_flag, tod_armed, sub_armed, tod_reject, irq, wake_req;
   logic square_wave_output;
   int miscompares = 0, check_count = 0, cyc = 0, ch;
   rtsa_top #(.TB_PER_TICK(1)) rtsa_top_i (.*);
   initial begin
      core_clk = 0;
      forever #4 core_clk = ~core_clk;
   end
   // both time base pins run; ext_sel picks one
   initial begin
      xtal_clk_in = 0;
      ext_clk_in = 1;
      forever #32 {xtal_clk_in, ext_clk_in} = ~{xtal_clk_in, ext_clk_in};
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task arm_tod(input logic [31:0] d, input logic ok);
      tod_target = seconds + d;
      tod_arm = 1;
      tick(1);
      tod_arm = 0;
      tick(1);
      check("tod_armed", tod_armed, ok);
      check("tod_reject", tod_reject, !ok);
   endtask : arm_tod
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 80000) begin
         miscompares++;
         test_done;
      end
   end
   // result watcher: alarm time against oldest note
   always @(posedge tod_flag) begin
      #1;
      check("alarm seconds", seconds, exp_q.size() ? exp_q.pop_front() : 32'hx);
   end
   initial begin
      rst = 1;
      {ext_sel, run_en, sec_load, tod_arm, tod_repeat, tod_ack, sub_arm} = '0;
      {sub_repeat, sub_ack, irq_en, wake_en, sqw_en} = '0;
      {sec_load_val, tod_target, sub_interval, trim_ppm, sqw_sel} = '0;
      rnd = 32'd20;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk) rst = 0;
      check("outputs after reset", {tod_flag, sub_flag, tod_armed, irq, wake_req}, 0);
      {run_en, irq_en, wake_en, sqw_en} = '1;
      sqw_sel = 2'd3;
      trim_ppm = 8'sd5;
      rnd = xs(rnd);
      sec_load_val = rnd >> 4;
      sec_load = 1;
      tick(1);
      sec_load = 0;
      check("seconds", seconds, sec_load_val);
      arm_tod(32'h0, 0);
      arm_tod(32'd1036801, 0);
      arm_tod(32'd1036800, 1);
      tod_repeat = 1;
      arm_tod(32'h1, 1);
      exp_q.push_back(tod_target);
      exp_q.push_back(tod_target + 32'h1);
      rnd = xs(rnd);
      sub_interval = {29'h0, rnd[2:0]} + 32'h1;
      {sub_repeat, ext_sel, sub_arm} = '1;
      tick(1);
      sub_arm = 0;
      check("sub_armed", sub_armed, 1);
      repeat (2) begin
         for (int i = 0; i < 200 && sub_flag !== 1'b1; i++) tick(1);
         check("sub_flag", sub_flag, 1);
         tick(1);
         check("irq wake", {irq, wake_req}, 2'b11);
         sub_ack = 1;
         tick(1);
         sub_ack = 0;
         check("sub_flag cleared", sub_flag, 0);
      end
      sub_interval = '0;
      sub_arm = 1;
      tick(1);
      sub_arm = 0;
      check("sub disarmed", sub_armed, 0);
      // one time base edge per tick here, so 4096 Hz runs at the raw time base rate
      for (int s = 3; s > 0; s--) begin
         sqw_sel = 2'(s);
         tick(2);
         ch = 0;
         sq = square_wave_output;
         for (int i = 0; i < 128; i++) begin
            tick(1);
            if (square_wave_output !== sq) ch++;
            sq = square_wave_output;
         end
         check("square wave edges", (s == 1) ? (ch > 2 && ch < 6) : (ch > 24), 1);
      end
      sqw_sel = 2'h0;
      tick(2);
      // repeating alarm fires at two wraps; the 1 Hz wave rises once before each
      repeat (2) begin
         ch = 0;
         sq = square_wave_output;
         for (int i = 0; i < 40000 && tod_flag !== 1'b1; i++) begin
            tick(1);
            if (square_wave_output !== sq) ch++;
            sq = square_wave_output;
         end
         check("1hz wave edges", ch, 1);
         check("tod_flag", tod_flag, 1);
         tick(1);
         check("irq", irq, 1);
         tod_ack = 1;
         tick(1);
         tod_ack = 0;
         check("tod_flag cleared", tod_flag, 0);
      end
      test_done;
   end
endmodule : rtsa_top_tb
